// file: hw/tolc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tolc_consts.svh"

module tolc_top
    import tolc_pkg::*;
(
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // conversion results, quarter degrees / supply codes
    input wire logic I_INT_TEMP_VLD,
    input wire logic [9:0] I_INT_TEMP,
    input wire logic I_EXT_TEMP_VLD,
    input wire logic [9:0] I_EXT_TEMP,
    input wire logic I_SUPPLY_VLD,
    input wire logic [9:0] I_SUPPLY,
    // corrected results and alert
    output logic [9:0] O_INT_TEMP,
    output logic [9:0] O_EXT_TEMP,
    output logic O_IRQ
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tolc_state_t s_r;
    tolc_state_t s_nxt;
    logic [9:0] int_corr;
    logic [9:0] ext_corr;
    logic [9:0] t_hi_q;
    logic [9:0] t_lo_q;
    logic int_above;
    logic int_below;
    logic sup_above;
    logic sup_below;
    logic bus_acc;
    logic wr_en;
    logic soft_rst;
    logic [3:0] st_set;
    logic [3:0] st_clr;

    // offset in degrees scaled to quarter degrees, saturated to 10 bits
    // saturation stops a large offset from wrapping a hot reading into a cold one
    function automatic logic [9:0] add_offset(input logic [9:0] raw, input logic [7:0] off);
        logic signed [10:0] sum;
        sum = 11'($signed(raw)) + 11'($signed({off, 2'b00}));
        if (sum > 11'sd511) begin
            add_offset = 10'h1ff;
        end else if (sum < -11'sd512) begin
            add_offset = 10'h200;
        end else begin
            add_offset = sum[9:0];
        end
    endfunction : add_offset

    // read mux over the register map, unmapped words read zero
    function automatic logic [31:0] read_back(input tolc_state_t st, input tolc_idx_t idx);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (idx == `TOLC_IDX_MASK1) begin
            d[7:0] = st.mask1;
        end else if (idx == `TOLC_IDX_MASK2) begin
            d[7:0] = st.mask2;
        end else if (idx == `TOLC_IDX_INT_OFF) begin
            d[7:0] = st.int_off;
        end else if (idx == `TOLC_IDX_EXT_OFF) begin
            d[7:0] = st.ext_off;
        end else if (idx == `TOLC_IDX_SUP_HI) begin
            d[7:0] = st.sup_hi;
        end else if (idx == `TOLC_IDX_SUP_LO) begin
            d[7:0] = st.sup_lo;
        end else if (idx == `TOLC_IDX_T_HI) begin
            d[7:0] = st.t_hi;
        end else if (idx == `TOLC_IDX_T_LO) begin
            d[7:0] = st.t_lo;
        end else if (idx == `TOLC_IDX_STATUS) begin
            d[3:0] = st.status;
        end else if (idx == `TOLC_IDX_INT_RES) begin
            d[9:0] = st.int_res;
        end else if (idx == `TOLC_IDX_EXT_RES) begin
            d[9:0] = st.ext_res;
        end else if (idx == `TOLC_IDX_SUP_RES) begin
            d[9:0] = st.sup_res;
        end
        read_back = d;
    endfunction : read_back

    // ----------------------------------------------------------------
    // offset correction and limit compare
    // ----------------------------------------------------------------
    // correction happens on the raw input so store and compare see one value
    assign int_corr = add_offset(I_INT_TEMP, s_r.int_off);
    assign ext_corr = add_offset(I_EXT_TEMP, s_r.ext_off);
    // limits are whole degrees, widened with zero fraction, sign kept
    assign t_hi_q = {s_r.t_hi, 2'b00};
    assign t_lo_q = {s_r.t_lo, 2'b00};

    tolc_limit_cmp #(
        .WIDTH(10),
        .SIGNED(1'b1)
    ) u_temp_cmp (
        .i_value(int_corr),
        .i_upper(t_hi_q),
        .i_lower(t_lo_q),
        .o_above(int_above),
        .o_at_or_below(int_below)
    );

    // supply limits have a quarter of the converter resolution
    tolc_limit_cmp #(
        .WIDTH(8),
        .SIGNED(1'b0)
    ) u_supply_cmp (
        .i_value(I_SUPPLY[9:2]),
        .i_upper(s_r.sup_hi),
        .i_lower(s_r.sup_lo),
        .o_above(sup_above),
        .o_at_or_below(sup_below)
    );

    // ----------------------------------------------------------------
    // events and bus strobes
    // ----------------------------------------------------------------
    always_comb begin
        st_set = 4'h0;
        st_set[`TOLC_ST_T_HI] = I_INT_TEMP_VLD & int_above;
        st_set[`TOLC_ST_T_LO] = I_INT_TEMP_VLD & int_below;
        st_set[`TOLC_ST_SUP_HI] = I_SUPPLY_VLD & sup_above;
        st_set[`TOLC_ST_SUP_LO] = I_SUPPLY_VLD & sup_below;
    end

    // address phase taken only when the bus is ready
    assign bus_acc = I_HSEL & I_HTRANS[1] & I_HREADY;
    assign wr_en = s_r.ph_vld & s_r.ph_wr;
    assign soft_rst = wr_en && s_r.ph_idx == `TOLC_IDX_CTRL && I_HWDATA[`TOLC_CTRL_SRST];
    assign st_clr = (wr_en && s_r.ph_idx == `TOLC_IDX_STATUS) ? I_HWDATA[3:0] : 4'h0;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // data-phase write; unmapped and read-only words are ignored
        if (wr_en) begin
            if (s_r.ph_idx == `TOLC_IDX_MASK1) begin
                s_nxt.mask1 = I_HWDATA[7:0];
            end else if (s_r.ph_idx == `TOLC_IDX_MASK2) begin
                s_nxt.mask2 = I_HWDATA[7:0];
            end else if (s_r.ph_idx == `TOLC_IDX_INT_OFF) begin
                s_nxt.int_off = I_HWDATA[7:0];
            end else if (s_r.ph_idx == `TOLC_IDX_EXT_OFF) begin
                s_nxt.ext_off = I_HWDATA[7:0];
            end else if (s_r.ph_idx == `TOLC_IDX_SUP_HI) begin
                s_nxt.sup_hi = I_HWDATA[7:0];
            end else if (s_r.ph_idx == `TOLC_IDX_SUP_LO) begin
                s_nxt.sup_lo = I_HWDATA[7:0];
            end else if (s_r.ph_idx == `TOLC_IDX_T_HI) begin
                s_nxt.t_hi = I_HWDATA[7:0];
            end else if (s_r.ph_idx == `TOLC_IDX_T_LO) begin
                s_nxt.t_lo = I_HWDATA[7:0];
            end
        end
        // a new event wins over a write-one-to-clear in the same cycle
        s_nxt.status = (s_r.status & ~st_clr) | st_set;
        // corrected results are stored as they are compared
        if (I_INT_TEMP_VLD) begin
            s_nxt.int_res = int_corr;
        end
        if (I_EXT_TEMP_VLD) begin
            s_nxt.ext_res = ext_corr;
        end
        if (I_SUPPLY_VLD) begin
            s_nxt.sup_res = I_SUPPLY;
        end
        // software reset returns every register to its default
        if (soft_rst) begin
            s_nxt.int_off = `TOLC_RST_OFF;
            s_nxt.ext_off = `TOLC_RST_OFF;
            s_nxt.sup_hi = `TOLC_RST_SUP_HI;
            s_nxt.sup_lo = `TOLC_RST_SUP_LO;
            s_nxt.t_hi = `TOLC_RST_T_HI;
            s_nxt.t_lo = `TOLC_RST_T_LO;
            s_nxt.mask1 = `TOLC_RST_MASK;
            s_nxt.mask2 = `TOLC_RST_MASK;
            s_nxt.status = `TOLC_RST_STATUS;
            s_nxt.int_res = `TOLC_RST_RES;
            s_nxt.ext_res = `TOLC_RST_RES;
            s_nxt.sup_res = `TOLC_RST_RES;
        end
        // address phase; read data sampled from the post-write state so a
        // read right behind a write sees the new value
        s_nxt.ph_vld = bus_acc;
        s_nxt.ph_wr = I_HWRITE;
        s_nxt.ph_idx = (I_HADDR[31:10] == 22'h0) ? I_HADDR[9:2] : 8'hff;
        if (bus_acc && !I_HWRITE) begin
            s_nxt.hrdata = read_back(s_nxt, s_nxt.ph_idx);
        end
    end

    // single register stage for all state
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            s_r.int_off <= `TOLC_RST_OFF;
            s_r.ext_off <= `TOLC_RST_OFF;
            s_r.sup_hi <= `TOLC_RST_SUP_HI;
            s_r.sup_lo <= `TOLC_RST_SUP_LO;
            s_r.t_hi <= `TOLC_RST_T_HI;
            s_r.t_lo <= `TOLC_RST_T_LO;
            s_r.mask1 <= `TOLC_RST_MASK;
            s_r.mask2 <= `TOLC_RST_MASK;
            s_r.status <= `TOLC_RST_STATUS;
            s_r.int_res <= `TOLC_RST_RES;
            s_r.ext_res <= `TOLC_RST_RES;
            s_r.sup_res <= `TOLC_RST_RES;
            s_r.ph_vld <= 1'b0;
            s_r.ph_wr <= 1'b0;
            s_r.ph_idx <= 8'h00;
            s_r.hrdata <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero wait states; every access answers okay
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign O_HRDATA = s_r.hrdata;
    assign O_INT_TEMP = s_r.int_res;
    assign O_EXT_TEMP = s_r.ext_res;
    // both supply events share one mask bit
    assign O_IRQ = (s_r.status[`TOLC_ST_T_HI] & ~s_r.mask1[`TOLC_M1_T_HI])
        | (s_r.status[`TOLC_ST_T_LO] & ~s_r.mask1[`TOLC_M1_T_LO])
        | (|s_r.status[`TOLC_ST_SUP_LO:`TOLC_ST_SUP_HI] & ~s_r.mask2[`TOLC_M2_SUP]);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RST_N);

    a_int_offset_add: assert property (
        I_INT_TEMP_VLD && !soft_rst && $signed(I_INT_TEMP) < 10'sd100
            && $signed(I_INT_TEMP) > -10'sd100
            && $signed(s_r.int_off) < 8'sd100 && $signed(s_r.int_off) > -8'sd100
        |=> $signed(O_INT_TEMP)
            == $past($signed(I_INT_TEMP)) + 10'($past($signed({s_r.int_off, 2'b00}))))
        else $error("internal result lacks offset");

    a_ext_offset_add: assert property (
        I_EXT_TEMP_VLD && !soft_rst && s_r.ext_off == 8'h00
        |=> O_EXT_TEMP == $past(I_EXT_TEMP))
        else $error("external result changed by zero offset");

    a_ext_offset_shift: assert property (
        I_EXT_TEMP_VLD && !soft_rst && $signed(I_EXT_TEMP) < 10'sd100
            && $signed(I_EXT_TEMP) > -10'sd100
            && $signed(s_r.ext_off) < 8'sd100 && $signed(s_r.ext_off) > -8'sd100
        |=> $signed(O_EXT_TEMP)
            == $past($signed(I_EXT_TEMP)) + 10'($past($signed({s_r.ext_off, 2'b00}))))
        else $error("external result lacks offset");

    a_supply_high: assert property (
        I_SUPPLY_VLD && !soft_rst && I_SUPPLY[9:2] > s_r.sup_hi
        |=> s_r.status[`TOLC_ST_SUP_HI])
        else $error("supply high event missed");

    a_supply_strict: assert property (
        I_SUPPLY_VLD && !soft_rst && I_SUPPLY[9:2] == s_r.sup_hi
            && !s_r.status[`TOLC_ST_SUP_HI]
        |=> !s_r.status[`TOLC_ST_SUP_HI])
        else $error("supply high event raised at equality");

    a_supply_low: assert property (
        I_SUPPLY_VLD && !soft_rst && I_SUPPLY[9:2] == s_r.sup_lo
        |=> s_r.status[`TOLC_ST_SUP_LO])
        else $error("supply low event missed at equality");

    a_temp_high: assert property (
        I_INT_TEMP_VLD && !soft_rst && $signed(int_corr) > $signed(t_hi_q)
        |=> s_r.status[`TOLC_ST_T_HI] ##1 s_r.status[`TOLC_ST_T_HI]
            || $past(st_clr[`TOLC_ST_T_HI]) || $past(soft_rst))
        else $error("temperature high event missed or lost");

    a_temp_strict: assert property (
        I_INT_TEMP_VLD && !soft_rst && int_corr == t_hi_q && !s_r.status[`TOLC_ST_T_HI]
        |=> !s_r.status[`TOLC_ST_T_HI])
        else $error("temperature high event raised at equality");

    a_temp_low: assert property (
        I_INT_TEMP_VLD && !soft_rst && int_corr == t_lo_q
        |=> s_r.status[`TOLC_ST_T_LO])
        else $error("temperature low event missed at equality");

    a_status_set_wins: assert property (
        wr_en && s_r.ph_idx == `TOLC_IDX_STATUS && |st_set
        |=> (s_r.status & $past(st_set)) == $past(st_set))
        else $error("event lost to a same-cycle status clear");

    a_limit_signed: assert property (
        $rose(s_r.status[`TOLC_ST_T_HI])
        |-> $past(I_INT_TEMP_VLD) && $past($signed(int_corr) > $signed({s_r.t_hi, 2'b00})))
        else $error("high event without signed exceed");

    a_irq_masked: assert property (
        (s_r.status & {~{2{s_r.mask2[`TOLC_M2_SUP]}}, ~s_r.mask1[1:0]}) == 4'h0 |-> !O_IRQ)
        else $error("alert raised by masked event");

    a_irq_unmasked: assert property (
        s_r.status[`TOLC_ST_SUP_LO] && !s_r.mask2[`TOLC_M2_SUP] |-> O_IRQ)
        else $error("unmasked supply event gives no alert");

    a_irq_temp_low: assert property (
        s_r.status[`TOLC_ST_T_LO] && !s_r.mask1[`TOLC_M1_T_LO] |-> O_IRQ)
        else $error("unmasked low temperature event gives no alert");

    a_soft_defaults: assert property (
        soft_rst |=> s_r.int_off == `TOLC_RST_OFF && s_r.t_lo == `TOLC_RST_T_LO
            && s_r.sup_hi == `TOLC_RST_SUP_HI && s_r.status == `TOLC_RST_STATUS)
        else $error("software reset left a register changed");

    c_temp_high: cover property (I_INT_TEMP_VLD && int_above ##1 O_IRQ);
    c_supply_low: cover property (I_SUPPLY_VLD && sup_below ##1 O_IRQ);
    c_set_clear: cover property (|(st_set & st_clr));
    c_soft_reset: cover property (soft_rst);
    c_offset_used: cover property (I_INT_TEMP_VLD && s_r.int_off != 8'h00);

endmodule : tolc_top

`default_nettype wire

// file: include/tolc_consts.svh
`ifndef TOLC_CONSTS_SVH
`define TOLC_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define TOLC_IDX_MASK1 8'h1d
`define TOLC_IDX_MASK2 8'h1e
`define TOLC_IDX_INT_OFF 8'h1f
`define TOLC_IDX_EXT_OFF 8'h20
`define TOLC_IDX_SUP_HI 8'h23
`define TOLC_IDX_SUP_LO 8'h24
`define TOLC_IDX_T_HI 8'h25
`define TOLC_IDX_T_LO 8'h26
`define TOLC_IDX_CTRL 8'h30
`define TOLC_IDX_STATUS 8'h31
`define TOLC_IDX_INT_RES 8'h32
`define TOLC_IDX_EXT_RES 8'h33
`define TOLC_IDX_SUP_RES 8'h34

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TOLC_RST_OFF 8'h00
`define TOLC_RST_SUP_HI 8'hc7
`define TOLC_RST_SUP_LO 8'h62
`define TOLC_RST_T_HI 8'h64
`define TOLC_RST_T_LO 8'hc9
`define TOLC_RST_MASK 8'h00
`define TOLC_RST_STATUS 4'h0
`define TOLC_RST_RES 10'h000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TOLC_ST_T_HI 0
`define TOLC_ST_T_LO 1
`define TOLC_ST_SUP_HI 2
`define TOLC_ST_SUP_LO 3
`define TOLC_M1_T_HI 0
`define TOLC_M1_T_LO 1
`define TOLC_M2_SUP 4
`define TOLC_CTRL_SRST 7
`define TOLC_FRAC_BITS 2

`endif

// file: include/tolc_pkg.sv
package tolc_pkg;

    // whole state of the top module
    typedef struct packed {
        logic [7:0] int_off;
        logic [7:0] ext_off;
        logic [7:0] sup_hi;
        logic [7:0] sup_lo;
        logic [7:0] t_hi;
        logic [7:0] t_lo;
        logic [7:0] mask1;
        logic [7:0] mask2;
        logic [3:0] status;
        logic [9:0] int_res;
        logic [9:0] ext_res;
        logic [9:0] sup_res;
        logic ph_vld;
        logic ph_wr;
        logic [7:0] ph_idx;
        logic [31:0] hrdata;
    } tolc_state_t;

    // register index taken from the bus address, used by the read mux
    typedef logic [7:0] tolc_idx_t;

endpackage : tolc_pkg

// file: hw/tolc_limit_cmp.sv
`timescale 1ns/1ps
`default_nettype none

// window comparator: above upper bound, or at/below lower bound
module tolc_limit_cmp #(
    parameter int unsigned WIDTH = 10,
    parameter bit SIGNED = 1'b1
) (
    // operands
    input wire logic [WIDTH-1:0] i_value,
    input wire logic [WIDTH-1:0] i_upper,
    input wire logic [WIDTH-1:0] i_lower,
    // results
    output logic o_above,
    output logic o_at_or_below
);

    // strict above, inclusive below
    always_comb begin
        if (SIGNED) begin
            o_above = $signed(i_value) > $signed(i_upper);
            o_at_or_below = $signed(i_value) <= $signed(i_lower);
        end else begin
            o_above = i_value > i_upper;
            o_at_or_below = i_value <= i_lower;
        end
    end

endmodule : tolc_limit_cmp

`default_nettype wire

// file: bench/tolc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tolc_top_tb;
    // ------------------------------------------------------------
    // stimulus, design hookup and counters
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] off;
        logic [9:0] t;
        logic [9:0] s;
        logic [9:0] e;
        logic [3:0] st;
    } tolc_row_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic it_vld = 1'b0;
    logic et_vld = 1'b0;
    logic sp_vld = 1'b0;
    logic [9:0] it = 10'h0;
    logic [9:0] et = 10'h0;
    logic [9:0] sp = 10'h0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic irq;
    wire logic [9:0] o_it;
    wire logic [9:0] o_et;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    tolc_row_t rows [11];

    always #2.5 clk = ~clk;

    tolc_top dut (
        .I_REF_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
        .I_INT_TEMP_VLD(it_vld), .I_INT_TEMP(it), .I_EXT_TEMP_VLD(et_vld), .I_EXT_TEMP(et),
        .I_SUPPLY_VLD(sp_vld), .I_SUPPLY(sp), .O_INT_TEMP(o_it), .O_EXT_TEMP(o_et),
        .O_IRQ(irq)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // single ahb transfer; each phase held until hready is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        // no wait limit here: only the bench timeout ends a stalled transfer
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        xfer(1'b1, idx, {24'h0, d}, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] want);
        logic [31:0] rd;
        xfer(1'b0, idx, 32'h0, rd);
        check(rd, want);
        check(32'(hresp), 32'h0);
        check(32'(hreadyout), 32'h1);
    endtask : rd_chk

    // register defaults; index 0x10 is unmapped and must read zero
    task automatic chk_defaults();
        logic [7:0] idx [10];
        logic [7:0] dv [10];
        idx = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h23, 8'h24, 8'h25, 8'h26, 8'h31, 8'h10};
        dv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hc7, 8'h62, 8'h64, 8'hc9, 8'h00, 8'h00};
        for (int i = 0; i < 10; i++) begin
            rd_chk(idx[i], {24'h0, dv[i]});
        end
        check(32'(irq), 32'h0);
        check(32'(o_it), 32'h0);
    endtask : chk_defaults

    // clear status, pulse all three results, then compare outputs and status
    task automatic run(input logic [9:0] t, input logic [9:0] s, input logic [9:0] e,
                       input logic [3:0] st, input logic q);
        wr(8'h31, 8'h0f);
        @(posedge clk);
        it_vld <= 1'b1;
        et_vld <= 1'b1;
        sp_vld <= 1'b1;
        it <= t;
        et <= t;
        sp <= s;
        @(posedge clk);
        it_vld <= 1'b0;
        et_vld <= 1'b0;
        sp_vld <= 1'b0;
        #1;
        check(32'(o_it), 32'(e));
        check(32'(o_et), 32'(e));
        rd_chk(8'h31, {28'h0, st});
        rd_chk(8'h32, 32'(e));
        rd_chk(8'h33, 32'(e));
        rd_chk(8'h34, 32'(s));
        check(32'(irq), 32'(q));
    endtask : run

    // cut a hang short; ceiling is over ten times the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        // offset, temp, supply, corrected, status under default limits
        rows[0] = '{8'h00, 10'h064, 10'h31c, 10'h064, 4'h0};
        rows[1] = '{8'h00, 10'h190, 10'h320, 10'h190, 4'h4};
        rows[2] = '{8'h00, 10'h191, 10'h188, 10'h191, 4'h9};
        rows[3] = '{8'h01, 10'h18d, 10'h18c, 10'h191, 4'h1};
        rows[4] = '{8'hff, 10'h194, 10'h258, 10'h190, 4'h0};
        rows[5] = '{8'h00, 10'h324, 10'h258, 10'h324, 4'h2};
        rows[6] = '{8'h00, 10'h325, 10'h258, 10'h325, 4'h0};
        rows[7] = '{8'hfe, 10'h32c, 10'h258, 10'h324, 4'h2};
        rows[8] = '{8'h7f, 10'h0c8, 10'h258, 10'h1ff, 4'h1};
        rows[9] = '{8'h80, 10'h39c, 10'h258, 10'h200, 4'h2};
        rows[10] = '{8'h05, 10'h010, 10'h258, 10'h024, 4'h0};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        chk_defaults();
        $display("test defaults done");
        foreach (rows[i]) begin
            wr(8'h1f, rows[i].off);
            wr(8'h20, rows[i].off);
            run(rows[i].t, rows[i].s, rows[i].e, rows[i].st, rows[i].st != 4'h0);
        end
        $display("test table done");
        // masks: events still latch but stay off the alert line
        wr(8'h1f, 8'h00);
        wr(8'h20, 8'h00);
        wr(8'h1d, 8'h01);
        run(10'h191, 10'h258, 10'h191, 4'h1, 1'b0);
        wr(8'h1d, 8'h02);
        #1;
        check(32'(irq), 32'h1);
        run(10'h324, 10'h258, 10'h324, 4'h2, 1'b0);
        wr(8'h1e, 8'h10);
        run(10'h325, 10'h320, 10'h325, 4'h4, 1'b0);
        run(10'h325, 10'h188, 10'h325, 4'h8, 1'b0);
        wr(8'h1e, 8'h00);
        #1;
        check(32'(irq), 32'h1);
        wr(8'h31, 8'h0f);
        #1;
        check(32'(irq), 32'h0);
        wr(8'h1d, 8'h00);
        $display("test masks done");
        // an event in the same cycle as its write-one-to-clear must survive
        fork
            wr(8'h31, 8'h0f);
            begin
                repeat (2) @(posedge clk);
                it_vld <= 1'b1;
                it <= 10'h191;
                @(posedge clk);
                it_vld <= 1'b0;
            end
        join
        rd_chk(8'h31, 32'h1);
        check(32'(irq), 32'h1);
        $display("test set and clear done");
        // negative temperature limits and low supply limits written by software, boundaries on both sides
        wr(8'h25, 8'hf6);
        wr(8'h26, 8'hec);
        rd_chk(8'h25, 32'hf6);
        rd_chk(8'h26, 32'hec);
        run(10'h3d9, 10'h258, 10'h3d9, 4'h1, 1'b1);
        run(10'h3d8, 10'h258, 10'h3d8, 4'h0, 1'b0);
        run(10'h3b0, 10'h258, 10'h3b0, 4'h2, 1'b1);
        run(10'h3b1, 10'h258, 10'h3b1, 4'h0, 1'b0);
        wr(8'h23, 8'h10);
        wr(8'h24, 8'h0f);
        run(10'h3c4, 10'h044, 10'h3c4, 4'h4, 1'b1);
        run(10'h3c4, 10'h043, 10'h3c4, 4'h0, 1'b0);
        run(10'h3c4, 10'h03f, 10'h3c4, 4'h8, 1'b1);
        $display("test limits done");
        // software reset, then a hardware reset in mid-run
        wr(8'h1f, 8'h11);
        wr(8'h1d, 8'h03);
        wr(8'h30, 8'h80);
        chk_defaults();
        wr(8'h25, 8'h01);
        wr(8'h20, 8'h22);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk_defaults();
        $display("test resets done");
        close_out();
    end
endmodule : tolc_top_tb

`default_nettype wire
